//--- shared/fifo_flags_defines.vh
`ifndef FIFO_FLAGS_DEFINES_VH
`define FIFO_FLAGS_DEFINES_VH

// ****************************************
// storage geometry
// ****************************************
`define FIFO_DATA_W 9
`define FIFO_ADDR_W 6
`define FIFO_PTR_W 7
`define FIFO_DEPTH 7'h40

// ****************************************
// offset registers
// ****************************************
`define OFFSET_REG_W 8
`define OFFSET_LOW_DEFAULT 8'h07
`define OFFSET_HIGH_DEFAULT 8'h00
`define OFFSET_USED_W 6

// ****************************************
// pointer crossing depth
// ****************************************
`define SYNC_STAGES 2

`endif

//--- hw/ptr_sync.v
`include "fifo_flags_defines.vh"

// two-stage carrier for a gray-coded pointer; stage one feeds only stage two
module ptr_sync (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [`FIFO_PTR_W-1:0] i_gray,
  output reg [`FIFO_PTR_W-1:0] o_gray
);
  reg [`FIFO_PTR_W-1:0] stage_one;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      stage_one <= {`FIFO_PTR_W{1'b0}};
      o_gray <= {`FIFO_PTR_W{1'b0}};
    end else begin
      stage_one <= i_gray; // R24
      o_gray <= stage_one; // R24
    end
  end
endmodule

//--- hw/flag_offset_regs.v
`include "fifo_flags_defines.vh"

module flag_offset_regs (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_load,
  input wire i_fetch,
  input wire [`OFFSET_REG_W-1:0] i_data_in,
  output reg [`OFFSET_REG_W-1:0] o_fetch_word,
  output wire [`OFFSET_USED_W-1:0] o_empty_offset,
  output wire [`OFFSET_USED_W-1:0] o_full_offset
);
  localparam [3:0] SEL_EMPTY_LOW = 4'h1;
  localparam [3:0] SEL_EMPTY_HIGH = 4'h2;
  localparam [3:0] SEL_FULL_LOW = 4'h4;
  localparam [3:0] SEL_FULL_HIGH = 4'h8;

  reg [3:0] sel;
  reg [`OFFSET_REG_W-1:0] empty_offset_low;
  reg [`OFFSET_REG_W-1:0] empty_offset_high;
  reg [`OFFSET_REG_W-1:0] full_offset_low;
  reg [`OFFSET_REG_W-1:0] full_offset_high;
  wire [15:0] empty_word;
  wire [15:0] full_word;

  // high register above low; depth only needs the low bits
  assign empty_word = {empty_offset_high, empty_offset_low}; // R23
  assign full_word = {full_offset_high, full_offset_low}; // R23
  assign o_empty_offset = empty_word[`OFFSET_USED_W-1:0]; // R23
  assign o_full_offset = full_word[`OFFSET_USED_W-1:0]; // R23

  always @* begin
    case (sel)
      SEL_EMPTY_LOW: o_fetch_word = empty_offset_low;
      SEL_EMPTY_HIGH: o_fetch_word = empty_offset_high;
      SEL_FULL_LOW: o_fetch_word = full_offset_low;
      SEL_FULL_HIGH: o_fetch_word = full_offset_high;
      default: o_fetch_word = 8'h00;
    endcase
  end

  // load and fetch share one rotating position; if both arrive, the fetch reads the old value, the load writes, and the position steps once
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      sel <= SEL_EMPTY_LOW;
      empty_offset_low <= `OFFSET_LOW_DEFAULT; // R19
      empty_offset_high <= `OFFSET_HIGH_DEFAULT;
      full_offset_low <= `OFFSET_LOW_DEFAULT; // R17
      full_offset_high <= `OFFSET_HIGH_DEFAULT;
    end else if (i_load || i_fetch) begin
      if (i_load) begin
        case (sel)
          SEL_EMPTY_LOW: empty_offset_low <= i_data_in; // R08
          SEL_EMPTY_HIGH: empty_offset_high <= i_data_in; // R08
          SEL_FULL_LOW: full_offset_low <= i_data_in; // R08
          SEL_FULL_HIGH: full_offset_high <= i_data_in; // R08
          default: empty_offset_low <= empty_offset_low;
        endcase
      end
      // fourth step wraps to the first register; position survives mode changes
      case (sel)
        SEL_EMPTY_LOW: sel <= SEL_EMPTY_HIGH; // R09
        SEL_EMPTY_HIGH: sel <= SEL_FULL_LOW;
        SEL_FULL_LOW: sel <= SEL_FULL_HIGH;
        SEL_FULL_HIGH: sel <= SEL_EMPTY_LOW; // R08 R10
        default: sel <= SEL_EMPTY_LOW;
      endcase
    end
  end
endmodule

//--- hw/dual_clock_fifo_flags.v
`include "fifo_flags_defines.vh"

// How it works
// (R01) reset-time high pin selects second write enable
// (R02) reset-time low pin selects offset load mode
// (R03) both enables active store next word
// (R04) either enable inactive holds input register
// (R05) full drives flag low, blocks writes
// (R06) read from full FIFO releases full flag
// (R07) four eight-bit offset registers, write and read
// (R08) loads rotate empty-low, empty-high, full-low, full-high
// (R09) leaving load mode keeps sequence position
// (R10) offset readback follows the same rotation
// (R11) never read and write offsets together
// (R12) full after depth writes without reads
// (R13) full flags change only on write edges
// (R14) empty flags change only on read edges
// (R15) empty when read pointer equals write pointer
// (R16) almost full at depth minus m words
// (R17) default full offset is seven
// (R18) almost empty while count at most n
// (R19) default empty offset is seven
// (R20) reset clears pointers, flags, output; offsets return to defaults
// (R21) valid read loads next word to output
// (R22) output drive low enables data outputs
// (R23) offset is high register above low register
// (R24) pointers cross through gray two-stage synchronisers
module dual_clock_fifo_flags (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_wclk,
  input wire i_rclk,
  input wire [`FIFO_DATA_W-1:0] i_data_in,
  input wire i_write_enable_a_n,
  input wire i_write_enable_b_or_load,
  input wire i_read_enable_a_n,
  input wire i_read_enable_b_n,
  input wire i_output_drive_n,
  output reg [`FIFO_DATA_W-1:0] o_data_out,
  output wire o_data_out_oe,
  output reg o_full_flag_n,
  output reg o_empty_flag_n,
  output reg o_prog_almost_full_n,
  output reg o_prog_almost_empty_n,
  output reg o_dual_write_mode
);
  // ****************************************
  // helpers
  // ****************************************
  function [`FIFO_PTR_W-1:0] to_gray;
    input [`FIFO_PTR_W-1:0] bin;
    begin
      to_gray = bin ^ (bin >> 1);
    end
  endfunction

  function [`FIFO_PTR_W-1:0] from_gray;
    input [`FIFO_PTR_W-1:0] gray;
    integer k;
    begin
      from_gray[`FIFO_PTR_W-1] = gray[`FIFO_PTR_W-1];
      for (k = `FIFO_PTR_W - 2; k >= 0; k = k - 1) begin
        from_gray[k] = from_gray[k + 1] ^ gray[k];
      end
    end
  endfunction

  // pointers carry one wrap bit, so the difference is the fill level even across a wrap
  function [`FIFO_PTR_W-1:0] ptr_distance;
    input [`FIFO_PTR_W-1:0] ahead;
    input [`FIFO_PTR_W-1:0] behind;
    begin
      ptr_distance = ahead - behind;
    end
  endfunction

  // ****************************************
  // port clock edges
  // ****************************************
  // write and read clocks are sampled pins; their rising edges pace each side
  reg wclk_q;
  reg rclk_q;
  wire w_edge;
  wire r_edge;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      wclk_q <= i_wclk;
      rclk_q <= i_rclk;
    end
  end

  assign w_edge = i_wclk & ~wclk_q;
  assign r_edge = i_rclk & ~rclk_q;

  // ****************************************
  // mode capture
  // ****************************************
  // the level is caught by the clock while reset is held, then frozen
  // a pin moving on the last reset clock still decides the mode; hold it steady through release
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_dual_write_mode <= i_write_enable_b_or_load; // R01 R02
    end
  end

  // ****************************************
  // request decode
  // ****************************************
  wire write_req;
  wire write_fire;
  wire read_req;
  wire read_fire;
  wire offset_load;
  wire offset_fetch;
  wire load_mode;
  wire [`OFFSET_REG_W-1:0] fetch_word;
  wire [`OFFSET_USED_W-1:0] empty_offset;
  wire [`OFFSET_USED_W-1:0] full_offset;

  // in either mode a data write needs enable a low and the shared pin high
  assign write_req = w_edge & ~i_write_enable_a_n & i_write_enable_b_or_load; // R03 R04
  assign write_fire = write_req & o_full_flag_n; // R05
  assign read_req = r_edge & ~i_read_enable_a_n & ~i_read_enable_b_n;

  // ****************************************
  // offset access
  // ****************************************
  assign load_mode = ~o_dual_write_mode; // R02
  assign offset_load = load_mode & w_edge & ~i_write_enable_a_n & ~i_write_enable_b_or_load; // R08
  assign offset_fetch = load_mode & read_req & ~i_write_enable_b_or_load; // R10
  // a fetch of an offset replaces the data read in that cycle
  assign read_fire = read_req & ~offset_fetch & o_empty_flag_n; // R15 R21

  flag_offset_regs u_offsets (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_load(offset_load),
    .i_fetch(offset_fetch),
    .i_data_in(i_data_in[`OFFSET_REG_W-1:0]),
    .o_fetch_word(fetch_word),
    .o_empty_offset(empty_offset),
    .o_full_offset(full_offset)
  ); // R07

  // ****************************************
  // storage and pointers
  // ****************************************
  reg [`FIFO_DATA_W-1:0] mem [0:(1 << `FIFO_ADDR_W) - 1];
  reg [`FIFO_DATA_W-1:0] input_word;
  reg [`FIFO_PTR_W-1:0] wptr;
  reg [`FIFO_PTR_W-1:0] rptr;
  reg [`FIFO_PTR_W-1:0] wptr_gray;
  reg [`FIFO_PTR_W-1:0] rptr_gray;
  wire [`FIFO_PTR_W-1:0] next_wptr;
  wire [`FIFO_PTR_W-1:0] next_rptr;
  wire [`FIFO_PTR_W-1:0] next_wptr_gray;
  wire [`FIFO_PTR_W-1:0] next_rptr_gray;
  reg [`FIFO_DATA_W-1:0] next_data_out;

  assign next_wptr = wptr + {{(`FIFO_PTR_W - 1){1'b0}}, write_fire};
  assign next_rptr = rptr + {{(`FIFO_PTR_W - 1){1'b0}}, read_fire};
  // only one bit of a gray pointer moves per step, so a half-caught value is still a neighbour
  assign next_wptr_gray = to_gray(next_wptr); // R24
  assign next_rptr_gray = to_gray(next_rptr); // R24

  // output register: an offset fetch takes the slot of a data read
  always @* begin
    next_data_out = o_data_out;
    if (offset_fetch) begin
      next_data_out = {1'b0, fetch_word}; // R10
    end else if (read_fire) begin
      next_data_out = mem[rptr[`FIFO_ADDR_W-1:0]]; // R21
    end
  end

  always @(posedge i_clk_sys) begin
    if (write_fire) begin
      mem[wptr[`FIFO_ADDR_W-1:0]] <= i_data_in; // R03
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      wptr <= {`FIFO_PTR_W{1'b0}}; // R20
      wptr_gray <= {`FIFO_PTR_W{1'b0}};
      input_word <= {`FIFO_DATA_W{1'b0}};
    end else begin
      wptr <= next_wptr;
      wptr_gray <= next_wptr_gray; // R24
      if (write_fire) begin
        input_word <= i_data_in; // R04
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      rptr <= {`FIFO_PTR_W{1'b0}}; // R20
      rptr_gray <= {`FIFO_PTR_W{1'b0}};
      o_data_out <= {`FIFO_DATA_W{1'b0}}; // R20
    end else begin
      rptr <= next_rptr;
      rptr_gray <= next_rptr_gray; // R24
      o_data_out <= next_data_out; // R21
    end
  end

  assign o_data_out_oe = ~i_output_drive_n; // R22

  // ****************************************
  // pointer crossing
  // ****************************************
  wire [`FIFO_PTR_W-1:0] rptr_gray_at_write;
  wire [`FIFO_PTR_W-1:0] wptr_gray_at_read;

  ptr_sync u_rptr_to_write (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_gray(rptr_gray),
    .o_gray(rptr_gray_at_write)
  ); // R24

  ptr_sync u_wptr_to_read (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_gray(wptr_gray),
    .o_gray(wptr_gray_at_read)
  ); // R24

  // ****************************************
  // flags
  // ****************************************
  // counts lag the far side by the crossing, so flags are pessimistic, never wrong
  wire [`FIFO_PTR_W-1:0] write_side_count;
  wire [`FIFO_PTR_W-1:0] read_side_count;
  wire [`FIFO_PTR_W-1:0] almost_full_level;
  wire [`FIFO_PTR_W-1:0] almost_empty_level;

  assign write_side_count = ptr_distance(next_wptr, from_gray(rptr_gray_at_write));
  assign read_side_count = ptr_distance(from_gray(wptr_gray_at_read), next_rptr);
  assign almost_full_level = `FIFO_DEPTH - {1'b0, full_offset}; // R16
  assign almost_empty_level = {1'b0, empty_offset}; // R18

  // ****************************************
  // write-side flag next values
  // ****************************************
  // recomputed only on a write pin edge; between edges the pair holds its level
  reg next_full_flag_n;
  reg next_prog_almost_full_n;

  always @* begin
    next_full_flag_n = o_full_flag_n;
    next_prog_almost_full_n = o_prog_almost_full_n;
    if (w_edge) begin
      next_full_flag_n = ~(write_side_count == `FIFO_DEPTH); // R05 R06 R12 R13
      next_prog_almost_full_n = ~(write_side_count >= almost_full_level); // R13 R16 R17
    end
  end

  // ****************************************
  // read-side flag next values
  // ****************************************
  // the crossed write pointer lags, so empty may stay low a few clocks after a write
  reg next_empty_flag_n;
  reg next_prog_almost_empty_n;

  always @* begin
    next_empty_flag_n = o_empty_flag_n;
    next_prog_almost_empty_n = o_prog_almost_empty_n;
    if (r_edge) begin
      next_empty_flag_n = ~(read_side_count == {`FIFO_PTR_W{1'b0}}); // R14 R15
      next_prog_almost_empty_n = ~(read_side_count <= almost_empty_level); // R14 R18 R19
    end
  end

  // ****************************************
  // flag registers
  // ****************************************
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_full_flag_n <= 1'b1; // R20
      o_prog_almost_full_n <= 1'b1; // R20
    end else begin
      o_full_flag_n <= next_full_flag_n;
      o_prog_almost_full_n <= next_prog_almost_full_n;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_empty_flag_n <= 1'b0; // R20
      o_prog_almost_empty_n <= 1'b0; // R20
    end else begin
      o_empty_flag_n <= next_empty_flag_n;
      o_prog_almost_empty_n <= next_prog_almost_empty_n;
    end
  end
endmodule

//--- tb/fifo_side_model.sv
`include "fifo_flags_defines.vh"
// ****************************************
// writer and reader on sampled clock pins
// ****************************************
module fifo_side_model (
  input wire logic i_clk_sys,
  output logic o_wclk,
  output logic o_rclk,
  output logic [`FIFO_DATA_W-1:0] o_data_in,
  output logic o_we_a_n,
  output logic o_we_b,
  output logic o_re_a_n,
  output logic o_re_b_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_wclk, o_rclk, o_data_in} = 11'h000;
    {o_we_a_n, o_we_b, o_re_a_n, o_re_b_n} = 4'hF;
  end
  task automatic mode(input logic v);
    @(posedge i_clk_sys) #1;
    o_we_b = v;
  endtask
  // clocks idle low, so every wr or rd call makes one edge; calls never overlap
  task automatic wr(input logic [`FIFO_DATA_W-1:0] d, input logic a_n, input logic b);
    @(posedge i_clk_sys) #1;
    o_data_in = d;
    o_we_a_n = a_n;
    o_we_b = b;
    o_wclk = 1'b1;
    @(posedge i_clk_sys) #1;
    o_wclk = 1'b0;
    o_we_a_n = 1'b1;
    o_data_in = ~d; // released bus must not look like held data
  endtask
  task automatic rd(input logic ra, input logic rb);
    @(posedge i_clk_sys) #1;
    o_re_a_n = ra;
    o_re_b_n = rb;
    o_rclk = 1'b1;
    @(posedge i_clk_sys) #1;
    o_rclk = 1'b0;
    {o_re_a_n, o_re_b_n} = 2'h3;
  endtask
endmodule

//--- tb/dual_clock_fifo_flags_asserts.sv
`include "fifo_flags_defines.vh"
// ****************************************
// flag and output timing checks
// ****************************************
module dual_clock_fifo_flags_asserts (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_wclk,
  input wire i_rclk,
  input wire i_write_enable_b_or_load,
  input wire i_read_enable_a_n,
  input wire i_read_enable_b_n,
  input wire i_output_drive_n,
  input wire [`FIFO_DATA_W-1:0] o_data_out,
  input wire o_data_out_oe,
  input wire o_full_flag_n,
  input wire o_empty_flag_n,
  input wire o_prog_almost_full_n,
  input wire o_prog_almost_empty_n,
  input wire o_dual_write_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  full_on_wedge_a: assert property ($changed(o_full_flag_n) |-> $past(i_wclk) && !$past(i_wclk, 2))
    else $error("full flag moved off a write edge");
  afull_on_wedge_a: assert property ($changed(o_prog_almost_full_n) |-> $past(i_wclk) && !$past(i_wclk, 2))
    else $error("almost full moved off a write edge");
  empty_on_redge_a: assert property ($changed(o_empty_flag_n) |-> $past(i_rclk) && !$past(i_rclk, 2))
    else $error("empty flag moved off a read edge");
  aempty_on_redge_a: assert property ($changed(o_prog_almost_empty_n) |-> $past(i_rclk) && !$past(i_rclk, 2))
    else $error("almost empty moved off a read edge");
  full_means_afull_a: assert property (!o_full_flag_n |-> !o_prog_almost_full_n)
    else $error("full without almost full");
  out_drive_a: assert property (o_data_out_oe == !i_output_drive_n)
    else $error("output enable wrong");
  out_hold_a: assert property (o_dual_write_mode && !(i_rclk && !$past(i_rclk) && !i_read_enable_a_n
    && !i_read_enable_b_n) |=> $stable(o_data_out))
    else $error("output changed without a read");
  empty_hold_a: assert property (o_dual_write_mode && !o_empty_flag_n |=> $stable(o_data_out))
    else $error("read taken while empty");
  mode_latch_a: assert property ($fell(i_rst) |-> o_dual_write_mode == $past(i_write_enable_b_or_load))
    else $error("mode not taken at reset");
  reset_state_a: assert property ($fell(i_rst) |-> o_full_flag_n && !o_empty_flag_n && o_data_out == 9'h000)
    else $error("reset state wrong");
endmodule

//--- tb/dual_clock_fifo_flags_tb.sv
`include "fifo_flags_defines.vh"
module dual_clock_fifo_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic oe_n = 1'b0;
  wire wclk, rclk, a_n, b, ra, rb, oe, ff, ef, prog_almost_full_n, prog_almost_empty_n, mode;
  wire [`FIFO_DATA_W-1:0] din, q;
  int miscompares = 0;
  int compares = 0;
  int i;
  logic [`FIFO_DATA_W-1:0] fetch_exp [5] = '{9'h003, 9'h000, 9'h002, 9'h000, 9'h003};
  always #25 clk = ~clk;
  fifo_side_model fifo_side_model_i (.i_clk_sys(clk), .o_wclk(wclk), .o_rclk(rclk), .o_data_in(din),
    .o_we_a_n(a_n), .o_we_b(b), .o_re_a_n(ra), .o_re_b_n(rb));
  dual_clock_fifo_flags dual_clock_fifo_flags_i (.i_clk_sys(clk), .i_rst(rst), .i_wclk(wclk),
    .i_rclk(rclk), .i_data_in(din), .i_write_enable_a_n(a_n), .i_write_enable_b_or_load(b),
    .i_read_enable_a_n(ra), .i_read_enable_b_n(rb), .i_output_drive_n(oe_n), .o_data_out(q),
    .o_data_out_oe(oe), .o_full_flag_n(ff), .o_empty_flag_n(ef), .o_prog_almost_full_n(prog_almost_full_n),
    .o_prog_almost_empty_n(prog_almost_empty_n), .o_dual_write_mode(mode));
  function automatic logic [`FIFO_DATA_W-1:0] val(input int k);
    return 9'(k * 5 + 259);
  endfunction
  task automatic chk(input logic [`FIFO_DATA_W-1:0] s, input logic [`FIFO_DATA_W-1:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_rst(input logic m);
    fifo_side_model_i.mode(m);
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
  endtask
  // far pointer needs three clocks to cross before the flag edge
  task automatic idle_r;
    repeat (3) @(posedge clk);
    fifo_side_model_i.rd(1'b1, 1'b1);
  endtask
  // ****************************************
  // dual write enable mode
  // ****************************************
  initial begin
    do_rst(1'b1);
    chk(9'({ff, prog_almost_full_n, ef, prog_almost_empty_n, mode}), 9'h019);
    fifo_side_model_i.rd(1'b0, 1'b0);
    chk(q, 9'h000);
    fifo_side_model_i.wr(9'h1AA, 1'b1, 1'b1);
    fifo_side_model_i.wr(9'h1AA, 1'b0, 1'b0);
    for (i = 0; i < 64; i++) begin
      fifo_side_model_i.wr(val(i), 1'b0, 1'b1);
      if (i == 55 || i == 56) chk(9'(prog_almost_full_n), 9'(i == 55));
    end
    chk(9'(ff), 9'h000);
    fifo_side_model_i.wr(9'h0FF, 1'b0, 1'b1);
    idle_r();
    chk(9'({ef, prog_almost_empty_n}), 9'h003);
    fifo_side_model_i.rd(1'b0, 1'b1);
    chk(q, 9'h000);
    for (i = 0; i < 64; i++) begin
      fifo_side_model_i.rd(1'b0, 1'b0);
      chk(q, val(i));
      if (i == 0) begin
        repeat (2) @(posedge clk);
        fifo_side_model_i.wr(9'h000, 1'b1, 1'b1);
        chk(9'(ff), 9'h001);
      end
      if (i == 55 || i == 56) chk(9'(prog_almost_empty_n), 9'(i == 55));
    end
    chk(9'(ef), 9'h000);
    oe_n = 1'b1;
    #1 chk(9'(oe), 9'h000);
    oe_n = 1'b0;
    // ****************************************
    // offset load mode
    // ****************************************
    do_rst(1'b0);
    chk(9'(mode), 9'h000);
    fifo_side_model_i.wr(9'h003, 1'b0, 1'b0);
    fifo_side_model_i.wr(9'h000, 1'b0, 1'b0);
    fifo_side_model_i.wr(val(0), 1'b0, 1'b1);
    fifo_side_model_i.wr(9'h002, 1'b0, 1'b0);
    fifo_side_model_i.wr(9'h000, 1'b0, 1'b0);
    for (i = 0; i < 5; i++) begin
      fifo_side_model_i.rd(1'b0, 1'b0);
      chk(q, fetch_exp[i]);
    end
    fifo_side_model_i.mode(1'b1);
    for (i = 1; i < 62; i++) begin
      fifo_side_model_i.wr(val(i), 1'b0, 1'b1);
      if (i == 2 || i == 3) begin
        idle_r();
        chk(9'(prog_almost_empty_n), 9'(i == 3));
      end
      if (i == 60 || i == 61) chk(9'(prog_almost_full_n), 9'(i == 60));
    end
    print_verdict();
  end
  initial begin
    #1000000;
    miscompares++;
    print_verdict();
  end
endmodule
bind dual_clock_fifo_flags dual_clock_fifo_flags_asserts dual_clock_fifo_flags_asserts_i (.i_clk_sys, .i_rst,
  .i_wclk, .i_rclk, .i_write_enable_b_or_load, .i_read_enable_a_n, .i_read_enable_b_n, .i_output_drive_n,
  .o_data_out, .o_data_out_oe, .o_full_flag_n, .o_empty_flag_n, .o_prog_almost_full_n, .o_prog_almost_empty_n,
  .o_dual_write_mode);
